// >>> core/cfbr_pkg.sv
// package: register map, field layout and routing codes for filter routing
package cfbr_pkg;

	// ------------------------------------------------------------
	// register offsets (16-bit registers, word index on the port)
	// ------------------------------------------------------------
	localparam logic [3:0]  ADDR_FILTER4_7  = 4'h0;
	localparam logic [3:0]  ADDR_FILTER8_11 = 4'h1;
	localparam logic [3:0]  ADDR_WORD_FOUR  = 4'h2;
	localparam logic [3:0]  ADDR_WORD_FIVE  = 4'h3;
	localparam logic [3:0]  ADDR_BUF_SELECT = 4'h4;
	localparam logic [3:0]  ADDR_ROUTE_STAT = 4'h5;

	// ------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------
	localparam int          PTR_WIDTH       = 4;
	localparam int          FIELD_LO_POS    = 0;
	localparam int          FIELD_ML_POS    = 4;
	localparam int          FIELD_MH_POS    = 8;
	localparam int          FIELD_HI_POS    = 12;
	localparam int          BYTE_LO_POS     = 0;
	localparam int          BYTE_HI_POS     = 8;
	localparam logic [15:0] POINTER_RESET   = 16'h0000;
	localparam logic [3:0]  DEST_FIFO       = 4'hf;
	localparam logic [3:0]  DEST_LAST_BUF   = 4'he;
	localparam int          NUM_BUFFERS     = 15;
	localparam int          FIRST_FILTER    = 4;
	localparam int          LAST_FILTER     = 11;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed
	{
		logic        valid;
		logic [3:0]  filter;
	} cfbr_hit_t;

	typedef struct packed
	{
		logic        valid;
		logic        to_fifo;
		logic [3:0]  buffer;
		logic [3:0]  filter;
	} cfbr_route_t;

	typedef struct packed
	{
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} cfbr_bus_t;

endpackage : cfbr_pkg

// >>> core/cfbr_data_buffer.sv
// module: data words four and five of the fifteen receive buffers
module cfbr_data_buffer
(
	input  wire logic                     ref_clk,
	input  wire logic [3:0]               buf_index,
	input  wire logic [1:0]               wr_four,
	input  wire logic [1:0]               wr_five,
	input  wire logic [15:0]              wdata,
	input  wire logic [3:0]               rd_index,
	output logic      [15:0]              word_four,
	output logic      [15:0]              word_five
);

	// ------------------------------------------------------------
	// storage, no reset: contents undefined until written
	// ------------------------------------------------------------
	logic [15:0] mem_four [cfbr_pkg::NUM_BUFFERS];
	logic [15:0] mem_five [cfbr_pkg::NUM_BUFFERS];

	// lane bit 1 writes the upper byte, bit 0 the lower
	wire logic       wr_ok   = buf_index < 4'(cfbr_pkg::NUM_BUFFERS);
	wire logic       rd_ok   = rd_index < 4'(cfbr_pkg::NUM_BUFFERS);
	wire logic [7:0] hi_byte = wdata[cfbr_pkg::BYTE_HI_POS +: 8];
	wire logic [7:0] lo_byte = wdata[cfbr_pkg::BYTE_LO_POS +: 8];

	always_ff @(posedge ref_clk)
	begin
		if (wr_ok && wr_four[1])
			mem_four[buf_index][cfbr_pkg::BYTE_HI_POS +: 8] <= hi_byte;
		if (wr_ok && wr_four[0])
			mem_four[buf_index][cfbr_pkg::BYTE_LO_POS +: 8] <= lo_byte;
		if (wr_ok && wr_five[1])
			mem_five[buf_index][cfbr_pkg::BYTE_HI_POS +: 8] <= hi_byte;
		if (wr_ok && wr_five[0])
			mem_five[buf_index][cfbr_pkg::BYTE_LO_POS +: 8] <= lo_byte;
	end

	assign word_four = rd_ok ? mem_four[rd_index] : 16'h0000;
	assign word_five = rd_ok ? mem_five[rd_index] : 16'h0000;

endmodule : cfbr_data_buffer

// >>> core/cfbr_top.sv
// module: filter 4-11 destination pointers and buffer data words 4/5
// Summary of operation
// - filter seven field routes: 0-14 buffer, 1111 FIFO
// - filter six pointer in bits 11-8
// - filter five pointer in bits 7-4
// - filter four pointer in bits 3-0
// - word four: byte 3 high, byte 2 low
// - word five: byte 5 high, byte 4 low
//
// Decided for this implementation: the register offsets and strobed register access.
module cfbr_top
(
	input  wire logic                     ref_clk,
	input  wire logic                     arst_n,
	input  wire cfbr_pkg::cfbr_bus_t      bus,
	output logic      [15:0]              rdata,
	input  wire cfbr_pkg::cfbr_hit_t      hit,
	input  wire logic                     rx_byte_we,
	input  wire logic [2:0]               rx_byte_idx,
	input  wire logic [7:0]               rx_byte,
	output cfbr_pkg::cfbr_route_t         route
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [1:0] lanes_for(input logic sw_hit,
		input logic rx_hit, input logic sw_other, input logic odd);
		if (sw_hit)
			lanes_for = 2'b11;
		else if (rx_hit && !sw_other)
			lanes_for = odd ? 2'b10 : 2'b01;
		else
			lanes_for = 2'b00;
	endfunction : lanes_for

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [15:0] filter4_7_buffer_pointer;
	logic [15:0] filter8_11_buffer_pointer;
	logic [3:0]  buf_select;
	logic [3:0]  last_dest;
	logic [3:0]  last_filter;
	logic        last_fifo;

	wire logic [3:0] filter_four_dest   =
		filter4_7_buffer_pointer[cfbr_pkg::FIELD_LO_POS +: 4];
	wire logic [3:0] filter_five_dest   =
		filter4_7_buffer_pointer[cfbr_pkg::FIELD_ML_POS +: 4];
	wire logic [3:0] filter_six_dest    =
		filter4_7_buffer_pointer[cfbr_pkg::FIELD_MH_POS +: 4];
	wire logic [3:0] filter_seven_dest  =
		filter4_7_buffer_pointer[cfbr_pkg::FIELD_HI_POS +: 4];
	wire logic [3:0] filter_eight_dest  =
		filter8_11_buffer_pointer[cfbr_pkg::FIELD_LO_POS +: 4];
	wire logic [3:0] filter_nine_dest   =
		filter8_11_buffer_pointer[cfbr_pkg::FIELD_ML_POS +: 4];
	wire logic [3:0] filter_ten_dest    =
		filter8_11_buffer_pointer[cfbr_pkg::FIELD_MH_POS +: 4];
	wire logic [3:0] filter_eleven_dest =
		filter8_11_buffer_pointer[cfbr_pkg::FIELD_HI_POS +: 4];

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	wire logic wr_ptr_a = bus.wr && bus.addr == cfbr_pkg::ADDR_FILTER4_7;
	wire logic wr_ptr_b = bus.wr && bus.addr == cfbr_pkg::ADDR_FILTER8_11;
	wire logic wr_sel   = bus.wr && bus.addr == cfbr_pkg::ADDR_BUF_SELECT;
	wire logic sw_four  = bus.wr && bus.addr == cfbr_pkg::ADDR_WORD_FOUR;
	wire logic sw_five  = bus.wr && bus.addr == cfbr_pkg::ADDR_WORD_FIVE;

	// ------------------------------------------------------------
	// hit routing
	// ------------------------------------------------------------
	wire logic hit_in_range = hit.valid
		&& hit.filter >= 4'(cfbr_pkg::FIRST_FILTER)
		&& hit.filter <= 4'(cfbr_pkg::LAST_FILTER);
	logic [3:0] hit_dest;
	always_comb
	begin
		case (hit.filter)
			4'h4:    hit_dest = filter_four_dest;
			4'h5:    hit_dest = filter_five_dest;
			4'h6:    hit_dest = filter_six_dest;
			4'h7:    hit_dest = filter_seven_dest;
			4'h8:    hit_dest = filter_eight_dest;
			4'h9:    hit_dest = filter_nine_dest;
			4'ha:    hit_dest = filter_ten_dest;
			4'hb:    hit_dest = filter_eleven_dest;
			default: hit_dest = 4'h0;
		endcase
	end
	wire logic        hit_fifo  = hit_dest == cfbr_pkg::DEST_FIFO;

	// ------------------------------------------------------------
	// receive bytes into the routed buffer's words four and five
	// ------------------------------------------------------------
	// bytes 2,3 land in word four, bytes 4,5 in word five
	wire logic rx_to_buf = rx_byte_we && !last_fifo;
	wire logic rx_four   = rx_to_buf && rx_byte_idx[2:1] == 2'b01;
	wire logic rx_five   = rx_to_buf && rx_byte_idx[2:1] == 2'b10;
	// odd bytes take the upper lane; a software write to word four or five drops the byte
	wire logic [15:0] cur_four;
	wire logic [15:0] cur_five;
	wire logic        sw_word    = sw_four || sw_five;
	wire logic [1:0]  lanes_four = lanes_for(sw_four, rx_four, sw_five,
		rx_byte_idx[0]);
	wire logic [1:0]  lanes_five = lanes_for(sw_five, rx_five, sw_four,
		rx_byte_idx[0]);
	wire logic [3:0]  wr_index   = sw_word ? buf_select : last_dest;
	wire logic [15:0] wr_word    = sw_word ? bus.wdata : {rx_byte, rx_byte};

	// ------------------------------------------------------------
	// buffer data words, read side follows the software select
	// ------------------------------------------------------------
	cfbr_data_buffer cfbr_data_buffer_inst
	(
		.ref_clk   (ref_clk),
		.buf_index (wr_index),
		.wr_four   (lanes_four),
		.wr_five   (lanes_five),
		.wdata     (wr_word),
		.rd_index  (buf_select),
		.word_four (cur_four),
		.word_five (cur_five)
	);

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	logic [15:0] next_rdata;
	always_comb
	begin
		case (bus.addr)
			cfbr_pkg::ADDR_FILTER4_7:  next_rdata = filter4_7_buffer_pointer;
			cfbr_pkg::ADDR_FILTER8_11: next_rdata = filter8_11_buffer_pointer;
			cfbr_pkg::ADDR_WORD_FOUR:  next_rdata = cur_four;
			cfbr_pkg::ADDR_WORD_FIVE:  next_rdata = cur_five;
			cfbr_pkg::ADDR_BUF_SELECT: next_rdata = {12'h000, buf_select};
			cfbr_pkg::ADDR_ROUTE_STAT: next_rdata = {7'h00, last_fifo,
				last_filter, last_dest};
			default:                   next_rdata = 16'h0000;
		endcase
	end

	// ------------------------------------------------------------
	// flip-flops
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			filter4_7_buffer_pointer <= cfbr_pkg::POINTER_RESET;
		else if (wr_ptr_a)
			filter4_7_buffer_pointer <= bus.wdata;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			filter8_11_buffer_pointer <= cfbr_pkg::POINTER_RESET;
		else if (wr_ptr_b)
			filter8_11_buffer_pointer <= bus.wdata;
	end

	// ------------------------------------------------------------
	// software buffer select
	// ------------------------------------------------------------
	// a value of 15 selects no buffer
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			buf_select <= 4'h0;
		else if (wr_sel)
			buf_select <= bus.wdata[3:0];
	end

	// ------------------------------------------------------------
	// read data, one cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata <= 16'h0000;
		else
			rdata <= bus.rd ? next_rdata : 16'h0000;
	end

	// ------------------------------------------------------------
	// route output
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			route <= '0;
		else
		begin
			route.valid   <= hit_in_range;
			route.to_fifo <= hit_in_range && hit_fifo;
			route.buffer  <= hit_in_range ? hit_dest : 4'h0;
			route.filter  <= hit_in_range ? hit.filter : 4'h0;
		end
	end

	// ------------------------------------------------------------
	// last routed hit
	// ------------------------------------------------------------
	// steers the receive bytes; a FIFO hit drops them
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			last_dest   <= 4'h0;
			last_filter <= 4'h0;
			last_fifo   <= 1'b0;
		end
		else if (hit_in_range)
		begin
			last_dest   <= hit_dest;
			last_filter <= hit.filter;
			last_fifo   <= hit_fifo;
		end
	end

endmodule : cfbr_top

// >>> dv/cfbr_properties.sv
// checker: routing and pointer readback properties
module cfbr_checker
(
	input wire logic                  ref_clk,
	input wire logic                  arst_n,
	input wire cfbr_pkg::cfbr_bus_t   bus,
	input wire logic [15:0]           rdata,
	input wire cfbr_pkg::cfbr_hit_t   hit,
	input wire logic                  rx_byte_we,
	input wire logic [2:0]            rx_byte_idx,
	input wire logic [7:0]            rx_byte,
	input wire cfbr_pkg::cfbr_route_t route
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] lo_ptr;
	logic [15:0] hi_ptr;
	logic [3:0]  want;
	logic        in_rng;
	// field of the hitting filter in the shadow pointers
	logic [31:0] both_ptr;
	assign both_ptr = {hi_ptr, lo_ptr};
	assign want = both_ptr[{hit.filter[3], hit.filter[1:0], 2'b00} +: 4];
	assign in_rng = hit.filter >= 4'h4 && hit.filter <= 4'hb;
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			{hi_ptr, lo_ptr} <= 32'h0000_0000;
		else if (bus.wr && bus.addr == cfbr_pkg::ADDR_FILTER4_7)
			lo_ptr <= bus.wdata;
		else if (bus.wr && bus.addr == cfbr_pkg::ADDR_FILTER8_11)
			hi_ptr <= bus.wdata;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	hit_routed_a: assert property (hit.valid && in_rng |=> route.valid)
		else $error("routed hit lost");
	route_quiet_a: assert property (!(hit.valid && in_rng) |=>
		!route.valid) else $error("route pulse without routed hit");
	dest_seven_a: assert property (hit.valid && hit.filter == 4'h7 |=>
		route.buffer == $past(want) && route.to_fifo == ($past(want) == 4'hf))
		else $error("filter seven dest wrong");
	dest_six_a: assert property (hit.valid && hit.filter == 4'h6 |=>
		route.buffer == $past(want)) else $error("filter six dest wrong");
	dest_five_a: assert property (hit.valid && hit.filter == 4'h5 |=>
		route.buffer == $past(want)) else $error("filter five dest wrong");
	dest_four_a: assert property (hit.valid && hit.filter == 4'h4 |=>
		route.buffer == $past(want)) else $error("filter four dest wrong");
	dest_high_a: assert property (hit.valid && in_rng && hit.filter[3] |=>
		route.buffer == $past(want)) else $error("filter 8-11 dest wrong");
	ptr_readback_a: assert property (bus.rd && bus.addr == 4'h0 |=>
		rdata == $past(lo_ptr)) else $error("pointer readback wrong");
endmodule : cfbr_checker

bind cfbr_top cfbr_checker cfbr_checker_inst (.ref_clk(ref_clk),
	.arst_n(arst_n), .bus(bus), .rdata(rdata), .hit(hit),
	.rx_byte_we(rx_byte_we), .rx_byte_idx(rx_byte_idx),
	.rx_byte(rx_byte), .route(route));

// >>> dv/can_filter_buffer_routing_bench.sv
// bench: pointer registers, hit routing and data words
module can_filter_buffer_routing_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  ref_clk = 1'b0;
	logic                  arst_n = 1'b0;
	cfbr_pkg::cfbr_bus_t   bus = '0;
	cfbr_pkg::cfbr_hit_t   hit = '0;
	logic                  rx_byte_we = 1'b0;
	logic [2:0]            rx_byte_idx = 3'h0;
	logic [7:0]            rx_byte = 8'h00;
	logic [15:0]           rdata;
	cfbr_pkg::cfbr_route_t route;
	int                    num_errors = 0;
	int                    samples_checked = 0;
	int                    cycles = 0;
	logic [31:0]           ptrs = 32'h7a2c_fe31;
	cfbr_top cfbr_top_inst (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus),
		.rdata(rdata), .hit(hit), .rx_byte_we(rx_byte_we),
		.rx_byte_idx(rx_byte_idx), .rx_byte(rx_byte), .route(route));
	initial
		forever #20 ref_clk = ~ref_clk;
	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	// one bus cycle; a read checks rdata in the following cycle
	task automatic op(input logic is_rd, input logic [3:0] a,
		input logic [15:0] d, input string what);
		@(posedge ref_clk);
		bus <= '{wr: !is_rd, rd: is_rd, addr: a, wdata: d};
		@(posedge ref_clk);
		bus <= '0;
		#1;
		if (is_rd)
			chk(what, rdata, d);
	endtask : op
	task automatic send_hit(input logic [3:0] f);
		logic [3:0] dst;
		dst = ptrs[{f[3], f[1:0], 2'b00} +: 4];
		@(posedge ref_clk);
		hit <= '{valid: 1'b1, filter: f};
		@(posedge ref_clk);
		hit <= '0;
		#1;
		if (f >= 4'h4 && f <= 4'hb)
			chk("route", 16'(route), {6'h0, 1'b1, dst == 4'hf, dst, f});
		else
			chk("route idle", 16'(route), 16'h0000);
	endtask : send_hit
	// bytes 1..6 back to back; only 2..5 belong to words four and five
	task automatic put_bytes(input logic [7:0] base);
		for (int i = 1; i < 7; i++)
		begin
			@(posedge ref_clk);
			rx_byte_we <= 1'b1;
			rx_byte_idx <= 3'(i);
			rx_byte <= base + 8'(i);
		end
		@(posedge ref_clk);
		rx_byte_we <= 1'b0;
	endtask : put_bytes
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			stop_test();
		end
	end
	initial
	begin
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
		op(1'b1, 4'h0, 16'h0000, "ptr4_7 reset");
		op(1'b1, 4'h1, 16'h0000, "ptr8_11 reset");
		op(1'b0, 4'h0, ptrs[15:0], "");
		op(1'b0, 4'h1, ptrs[31:16], "");
		op(1'b0, 4'h9, 16'hffff, "");
		op(1'b1, 4'h0, ptrs[15:0], "ptr4_7");
		op(1'b1, 4'h1, ptrs[31:16], "ptr8_11");
		op(1'b1, 4'h9, 16'h0000, "unmapped");
		$display("test done: registers");
		for (int f = 0; f < 16; f++)
			send_hit(4'(f));
		op(1'b1, 4'h5, 16'h00b7, "route status");
		$display("test done: routing");
		send_hit(4'h4);
		put_bytes(8'h10);
		send_hit(4'h7);
		put_bytes(8'h80);
		op(1'b0, 4'h4, 16'h0001, "");
		op(1'b1, 4'h2, 16'h1312, "word four");
		op(1'b1, 4'h3, 16'h1514, "word five");
		op(1'b0, 4'h4, 16'h000e, "");
		op(1'b0, 4'h2, 16'ha55a, "");
		op(1'b1, 4'h2, 16'ha55a, "sw word four");
		op(1'b1, 4'h4, 16'h000e, "buffer select");
		$display("test done: data words");
		stop_test();
	end
endmodule : can_filter_buffer_routing_bench
